// *** pgk_pkg.sv ***
// Shared constants and carrier types for the PWM sync, conversion and shutdown block
package pgk_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS       = 4000;
    localparam int SYNC_WIDTH_CYCLES   = 32;
    localparam int IFB_DEADLINE_CYCLES = 100;
    localparam int AUX_DEADLINE_SPEC   = 200;
    localparam int GATE_UPDATE_MAX     = 2;
    localparam int FAULT_MIN_CYCLES    = 32;
    localparam int KILL_DEADLINE       = 100;
    localparam int HOLD_TIME_US        = 10;
    // Longest time: round down
    localparam int HOLD_CYCLES = (HOLD_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int AUX_DEADLINE_CYCLES =
        (AUX_DEADLINE_SPEC < HOLD_CYCLES) ? AUX_DEADLINE_SPEC : HOLD_CYCLES;

    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int         AGE_W         = 8;
    localparam int         SYNC_CNT_W    = 6;
    localparam int         AUX_CHANNELS  = 6;
    localparam logic [2:0] AUX_CH_FIRST  = 3'h1;
    localparam logic [2:0] AUX_CH_LAST   = 3'h6;
    localparam logic [2:0] AUX_CH_RESET  = 3'h6;
    localparam logic [5:0] GATE_RESET    = 6'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic phase_u_high_gate;
        logic phase_u_low_gate;
        logic phase_v_high_gate;
        logic phase_v_low_gate;
        logic phase_w_high_gate;
        logic phase_w_low_gate;
    } pgk_gate_type;

    typedef struct packed {
        logic       ifb_start;
        logic       aux_start;
        logic [2:0] aux_channel;
    } pgk_conv_req_type;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_IFB  = 2'b01,
        SEQ_AUX  = 2'b11
    } pgk_seq_type;

endpackage

// *** pgk_fault_filter.sv ***
// Shutdown pin synchroniser, polarity select and digital filter
`timescale 1ns/100ps
module pgk_fault_filter import pgk_pkg::*; #(
    parameter int FILTER_CYCLES = FAULT_MIN_CYCLES
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // Pin and configuration
    input  wire logic pin_in,
    input  wire logic active_high,
    // Filtered fault level
    output logic      fault_out
);

    localparam int CW = $clog2(FILTER_CYCLES + 1);

    initial begin
        if (FILTER_CYCLES < 1 || FILTER_CYCLES > FAULT_MIN_CYCLES) begin
            $error("FILTER_CYCLES out of range");
        end
    end

    logic          meta_reg;
    logic          sync_reg;
    logic          state_reg;
    logic          state_next;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic          level;

    always_comb begin
        level      = ~(sync_reg ^ active_high);
        state_next = state_reg;
        count_next = '0;
        // A new level must persist for FILTER_CYCLES samples; glitches restart the count
        if (level != state_reg) begin
            if (count_reg == CW'(FILTER_CYCLES - 1)) begin
                state_next = level;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_reg  <= 1'b0;
            sync_reg  <= 1'b0;
            state_reg <= 1'b0;
            count_reg <= '0;
        end else begin
            meta_reg  <= pin_in;
            sync_reg  <= meta_reg;
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    assign fault_out = state_reg;

endmodule

// *** pgk_pwm_sync.sv ***
// Carrier counter, sync strobe, conversion scheduling and shutdown for the three-phase PWM stage
//
// Operation
// - The sync strobe is one pulse of 32 clock cycles.
// - The current-feedback conversion must finish within 100 cycles of the strobe.
// - The scheduled auxiliary conversion must finish within 200 cycles of the strobe.
// - Auxiliary channels 1 to 6 are taken in turn, each once per six strobes.
// - New gate states appear at most 2 cycles after the strobe.
// - A recognised shutdown forces all gates inactive within 100 cycles.
// - A sampled value is converted within 10 microseconds of sampling.
// - Shutdown negates all six gates, and its active level is selectable.
// - Shutdown is digitally filtered and each gate has its own selectable polarity.
`timescale 1ns/100ps
module pgk_pwm_sync import pgk_pkg::*; #(
    parameter int CNT_W         = 16,
    parameter int FILTER_CYCLES = FAULT_MIN_CYCLES
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // Fault pin and configuration
    input  wire logic             pwm_fault_shutdown_in,
    input  wire logic             fault_active_high,
    input  wire logic [5:0]       gate_active_high,
    // Carrier and duty settings
    input  wire logic [CNT_W-1:0] carrier_period,
    input  wire logic [CNT_W-1:0] duty_u,
    input  wire logic [CNT_W-1:0] duty_v,
    input  wire logic [CNT_W-1:0] duty_w,
    // Converter handshake
    input  wire logic             ifb_done,
    input  wire logic             aux_done,
    output pgk_conv_req_type      conv_req,
    output logic                  ifb_late,
    output logic                  aux_late,
    // Strobe, gates, status
    output logic                  sync_strobe,
    output pgk_gate_type          gate,
    output logic                  fault_active
);

    initial begin
        if (CNT_W < 8 || CNT_W > 32) begin
            $error("CNT_W out of range");
        end
        if (FILTER_CYCLES + 4 > KILL_DEADLINE) begin
            $error("FILTER_CYCLES too long for the shutdown latency");
        end
    end

    // ****************************************************************
    // Carrier counter and sync strobe
    // ****************************************************************
    logic [CNT_W-1:0]      cnt_reg, cnt_next;
    logic [CNT_W-1:0]      shu_reg, shu_next;
    logic [CNT_W-1:0]      shv_reg, shv_next;
    logic [CNT_W-1:0]      shw_reg, shw_next;
    logic [SYNC_CNT_W-1:0] swid_reg, swid_next;
    logic                  sync_reg, sync_next;
    logic                  reload;

    always_comb begin
        reload    = (cnt_reg >= carrier_period);
        cnt_next  = reload ? '0 : cnt_reg + 1'b1;
        shu_next  = reload ? duty_u : shu_reg;
        shv_next  = reload ? duty_v : shv_reg;
        shw_next  = reload ? duty_w : shw_reg;
        swid_next = swid_reg;
        if (reload) begin
            swid_next = SYNC_CNT_W'(SYNC_WIDTH_CYCLES - 1);
        end else if (swid_reg != '0) begin
            swid_next = swid_reg - 1'b1;
        end
        sync_next = reload | (swid_reg != '0);
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_reg  <= '0;
            shu_reg  <= '0;
            shv_reg  <= '0;
            shw_reg  <= '0;
            swid_reg <= '0;
            sync_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            shu_reg  <= shu_next;
            shv_reg  <= shv_next;
            shw_reg  <= shw_next;
            swid_reg <= swid_next;
            sync_reg <= sync_next;
        end
    end

    // ****************************************************************
    // Gate outputs and shutdown
    // ****************************************************************
    logic         fault_filt;
    logic         fault_reg;
    pgk_gate_type gate_reg, gate_next;
    logic [5:0]   raw;

    pgk_fault_filter #(
        .FILTER_CYCLES (FILTER_CYCLES)
    ) u_filter (
        .mclk        (mclk),
        .reset       (reset),
        .pin_in      (pwm_fault_shutdown_in),
        .active_high (fault_active_high),
        .fault_out   (fault_filt)
    );

    // Compare against next count and shadows so the new period shows with the strobe
    always_comb begin
        raw[5] = (cnt_next < shu_next);
        raw[4] = ~raw[5];
        raw[3] = (cnt_next < shv_next);
        raw[2] = ~raw[3];
        raw[1] = (cnt_next < shw_next);
        raw[0] = ~raw[1];
        if (fault_filt) begin
            gate_next = pgk_gate_type'(~gate_active_high);
        end else begin
            gate_next = pgk_gate_type'(raw ^ ~gate_active_high);
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            gate_reg  <= pgk_gate_type'(GATE_RESET);
            fault_reg <= 1'b0;
        end else begin
            gate_reg  <= gate_next;
            fault_reg <= fault_filt;
        end
    end

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    pgk_seq_type      state_reg, state_next;
    logic [AGE_W-1:0] age_reg, age_next;
    logic [2:0]       ch_reg, ch_next;
    pgk_conv_req_type req_reg, req_next;
    logic             ifbl_reg, ifbl_next;
    logic             auxl_reg, auxl_next;

    always_comb begin
        state_next = state_reg;
        age_next   = (age_reg == '1) ? age_reg : age_reg + 1'b1;
        ch_next    = ch_reg;
        req_next   = '{ifb_start: 1'b0, aux_start: 1'b0, aux_channel: ch_reg};
        ifbl_next  = 1'b0;
        auxl_next  = 1'b0;
        if (reload) begin
            // A strobe during an unfinished sequence restarts it
            state_next         = SEQ_IFB;
            age_next           = '0;
            ch_next            = (ch_reg == AUX_CH_LAST) ? AUX_CH_FIRST : ch_reg + 1'b1;
            req_next.ifb_start = 1'b1;
        end else begin
            unique case (state_reg)
                SEQ_IDLE: begin
                end
                SEQ_IFB: begin
                    if (ifb_done || age_reg == AGE_W'(IFB_DEADLINE_CYCLES)) begin
                        ifbl_next          = ~ifb_done;
                        state_next         = SEQ_AUX;
                        req_next.aux_start = 1'b1;
                    end
                end
                SEQ_AUX: begin
                    if (aux_done || age_reg == AGE_W'(AUX_DEADLINE_CYCLES)) begin
                        auxl_next  = ~aux_done;
                        state_next = SEQ_IDLE;
                    end
                end
                default: begin
                    state_next = SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= SEQ_IDLE;
            age_reg   <= '0;
            ch_reg    <= AUX_CH_RESET;
            req_reg   <= '0;
            ifbl_reg  <= 1'b0;
            auxl_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            age_reg   <= age_next;
            ch_reg    <= ch_next;
            req_reg   <= req_next;
            ifbl_reg  <= ifbl_next;
            auxl_reg  <= auxl_next;
        end
    end

    assign sync_strobe  = sync_reg;
    assign gate         = gate_reg;
    assign fault_active = fault_reg;
    assign conv_req     = req_reg;
    assign ifb_late     = ifbl_reg;
    assign aux_late     = auxl_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    localparam int IFB_BOUND = 102;
    localparam int AUX_BOUND = 202;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sync_width_a: assert property (
        $rose(sync_reg) && carrier_period >= CNT_W'(SYNC_WIDTH_CYCLES)
        |-> sync_reg[*8] ##24 sync_reg ##1 (!sync_reg || cnt_reg == '0))
        else $error("sync strobe width wrong");

    ifb_deadline_a: assert property (
        req_reg.ifb_start |-> ##[1:IFB_BOUND] (state_reg != SEQ_IFB || req_reg.ifb_start))
        else $error("current conversion overran");

    aux_deadline_a: assert property (
        req_reg.ifb_start |-> ##[1:AUX_BOUND] (state_reg == SEQ_IDLE || req_reg.ifb_start))
        else $error("aux conversion overran");

    aux_rotation_a: assert property (
        reload |=> ch_reg == (($past(ch_reg) == AUX_CH_LAST) ? AUX_CH_FIRST
                                                              : $past(ch_reg) + 3'h1))
        else $error("aux channel rotation wrong");

    gate_update_a: assert property (
        reload && !fault_filt |=> gate_reg.phase_u_high_gate ==
            (($past(duty_u) != '0) ^ ~$past(gate_active_high[5])))
        else $error("gate not updated at strobe");

    kill_state_a: assert property (
        fault_reg |-> gate_reg == pgk_gate_type'(~$past(gate_active_high)))
        else $error("gates not killed on shutdown");

    gate_pair_a: assert property (
        !fault_reg && !$past(fault_filt) && !$past(reset) |->
            ((gate_reg.phase_v_high_gate ^ ~gate_active_high[3]) !=
             (gate_reg.phase_v_low_gate ^ ~gate_active_high[2])) || $changed(gate_active_high))
        else $error("phase pair not complementary");

    sync_align_a: assert property (
        $rose(sync_reg) |-> cnt_reg == '0 && req_reg.ifb_start)
        else $error("strobe not at reload");

    fault_sense_a: assert property (
        $rose(fault_reg) |-> $past(fault_active_high, 2) == $past(pwm_fault_shutdown_in, 4))
        else $error("shutdown polarity wrong");

endmodule

// *** pgk_conv_model.sv ***
// Behavioural converter that answers the block's start pulses after a set delay
`timescale 1ns/100ps
module pgk_conv_model import pgk_pkg::*; (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // Requests and answer delays, zero means never answer
    input  wire pgk_conv_req_type conv_req,
    input  wire logic [7:0]       ifb_wait,
    input  wire logic [7:0]       aux_wait,
    // Completion pulses
    output logic                  ifb_done,
    output logic                  aux_done
);
    logic [7:0] ifb_cnt_reg;
    logic [7:0] aux_cnt_reg;

    // A new start reloads the count, so an aborted conversion never answers late
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ifb_cnt_reg <= 8'h00;
            aux_cnt_reg <= 8'h00;
            ifb_done    <= 1'b0;
            aux_done    <= 1'b0;
        end else begin
            ifb_done    <= (ifb_cnt_reg == 8'h01);
            aux_done    <= (aux_cnt_reg == 8'h01);
            ifb_cnt_reg <= conv_req.ifb_start ? ifb_wait : ifb_cnt_reg - {7'h00, |ifb_cnt_reg};
            aux_cnt_reg <= conv_req.aux_start ? aux_wait : aux_cnt_reg - {7'h00, |aux_cnt_reg};
        end
    end
endmodule

// *** pgk_pwm_sync_test.sv ***
// Self-checking testbench for the PWM sync, conversion and shutdown block
`timescale 1ns/100ps
module pgk_pwm_sync_test import pgk_pkg::*; ;
    logic             mclk = 1'b0;
    logic             reset = 1'b1;
    logic             pin = 1'b0;
    logic             fah = 1'b1;
    logic [5:0]       gah = 6'h3F;
    logic [2:0][15:0] duty = '0;
    logic [15:0]      period = 16'h0040;
    logic [7:0]       ifb_wait = 8'h05;
    logic [7:0]       aux_wait = 8'h14;
    logic             ifb_done, aux_done, ifb_late, aux_late, sync_strobe, fault_active;
    pgk_conv_req_type conv_req;
    pgk_gate_type     gate;
    logic [2:0]       ch = 3'h6;
    int               n_errors = 0;
    int               num_checks = 0;

    always #2 mclk = ~mclk;

    pgk_pwm_sync #(.CNT_W(16), .FILTER_CYCLES(FAULT_MIN_CYCLES)) uut (
        .mclk(mclk), .reset(reset), .pwm_fault_shutdown_in(pin), .fault_active_high(fah),
        .gate_active_high(gah), .carrier_period(period), .duty_u(duty[2]),
        .duty_v(duty[1]), .duty_w(duty[0]), .ifb_done(ifb_done), .aux_done(aux_done),
        .conv_req(conv_req), .ifb_late(ifb_late), .aux_late(aux_late),
        .sync_strobe(sync_strobe), .gate(gate), .fault_active(fault_active));

    pgk_conv_model conv (.mclk(mclk), .reset(reset), .conv_req(conv_req),
        .ifb_wait(ifb_wait), .aux_wait(aux_wait), .ifb_done(ifb_done), .aux_done(aux_done));

    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    // High side on while count is below duty; active-low gates are inverted
    function automatic logic [5:0] exp_gate(input logic [15:0] c, input logic [2:0][15:0] d);
        logic [5:0] g;
        for (int i = 0; i < 3; i++) begin
            g[2*i+1] = c < d[i];
            g[2*i]   = !(c < d[i]);
        end
        return g ^ ~gah;
    endfunction

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic do_reset;
        @(posedge mclk);
        reset <= 1'b1;
        ch = 3'h6;
        repeat (8) @(posedge mclk);
        #1;
        chk("gate in reset", 16'(GATE_RESET), 16'(gate));
        chk("sync in reset", 16'h0000, 16'(sync_strobe));
        @(posedge mclk);
        reset <= 1'b0;
    endtask

    task automatic wait_sync;
        logic prev;
        int   i;
        prev = sync_strobe;
        for (i = 0; i < 2000; i++) begin
            @(posedge mclk);
            #1;
            if (sync_strobe === 1'b1 && prev === 1'b0) break;
            prev = sync_strobe;
        end
        chk("sync found", 16'h0001, 16'(i < 2000));
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic run_periods(input int n);
        logic [2:0][15:0] ed;
        int               na;
        wait_sync();
        for (int p = 0; p < n; p++) begin
            ed = duty;
            ch = (ch == AUX_CH_LAST) ? AUX_CH_FIRST : ch + 3'h1;
            na = 0;
            chk("ifb start", 16'h0001, 16'(conv_req.ifb_start));
            for (int k = 0; k <= period; k++) begin
                if (k > 0) begin
                    @(posedge mclk);
                    // Mid-period duty change must wait for the next reload
                    if (k == 5) duty <= {16'($urandom_range(period + 1)),
                        16'($urandom_range(period + 1)), 16'($urandom_range(period + 1))};
                    #1;
                end
                chk("sync level", 16'(k < SYNC_WIDTH_CYCLES), 16'(sync_strobe));
                chk("gates", 16'(exp_gate(16'(k), ed)), 16'(gate));
                chk("late flags", 16'h0000, 16'({ifb_late, aux_late}));
                // Channel is only meaningful alongside its start pulse
                if (conv_req.aux_start === 1'b1) begin
                    chk("aux channel", 16'(ch), 16'(conv_req.aux_channel));
                end
                na += int'(conv_req.aux_start);
            end
            chk("aux starts", 16'h0001, 16'(na));
            @(posedge mclk);
            #1;
            chk("next sync", 16'h0001, 16'(sync_strobe));
        end
    endtask

    task automatic late_test;
        int fi;
        int fa;
        fi = -1;
        fa = -1;
        wait_sync();
        for (int k = 1; k < 260; k++) begin
            @(posedge mclk);
            #1;
            if (ifb_late === 1'b1 && fi < 0) fi = k;
            if (aux_late === 1'b1 && fa < 0) fa = k;
            if (ifb_late === 1'b1) begin
                chk("aux start on late", 16'h0001, 16'(conv_req.aux_start));
            end
        end
        chk("ifb late cycle", 16'(IFB_DEADLINE_CYCLES + 1), 16'(fi));
        chk("aux late cycle", 16'(AUX_DEADLINE_CYCLES + 1), 16'(fa));
    endtask

    task automatic fault_test(input logic pol);
        int lat;
        int i;
        @(posedge mclk);
        fah <= pol;
        pin <= !pol;
        repeat (60) @(posedge mclk);
        pin <= pol;
        repeat (FAULT_MIN_CYCLES - 1) @(posedge mclk);
        pin <= !pol;
        for (int k = 0; k < 40; k++) begin
            @(posedge mclk);
            #1;
            chk("short pulse", 16'h0000, 16'(fault_active));
        end
        @(posedge mclk);
        pin <= pol; // held well past the minimum width
        lat = -1;
        for (int k = 1; k <= 150; k++) begin
            @(posedge mclk);
            #1;
            if (lat > 0) chk("gates held off", {10'h000, ~gah}, 16'(gate));
            if (lat < 0 && fault_active === 1'b1 && gate === ~gah) lat = k;
        end
        chk("kill in time", 16'h0001, 16'(lat > 0 && lat <= KILL_DEADLINE));
        @(posedge mclk);
        pin <= !pol;
        for (i = 0; i < 100 && fault_active !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
        end
        chk("fault released", 16'h0000, 16'(fault_active));
    endtask

    initial begin
        void'($urandom(32'h2AB53BEC));
        for (int t = 0; t < 3; t++) begin
            @(posedge mclk);
            gah <= 6'($urandom);
            period <= 16'($urandom_range(90, 50));
            do_reset();
            // First run takes the all-off and all-on duty corners
            duty <= (t == 0) ? {16'h0000, period + 16'h0001, 16'h0001}
                : {16'($urandom_range(50)), 16'($urandom_range(50)), 16'($urandom_range(50))};
            run_periods(7);
            $display("test periods %0d done", t);
        end
        @(posedge mclk);
        period <= 16'd300;
        ifb_wait <= 8'h00;
        aux_wait <= 8'h00;
        do_reset();
        late_test();
        $display("test deadlines done");
        @(posedge mclk);
        ifb_wait <= 8'h05;
        aux_wait <= 8'h14;
        period <= 16'd60;
        fault_test(1'b1);
        fault_test(1'b0);
        $display("test shutdown done");
        end_of_test();
    end

    // Whole run is about 3000 cycles
    initial begin
        #80000;
        n_errors++;
        end_of_test();
    end
endmodule
